//--- hw/regulator_config_setpoint_select.sv
`include "regsel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module regulator_config_setpoint_select (
   // clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    rstn_in,
   // serial parameter port
   input  wire regsel_pkg::par_req_t    par_req_in,
   output var  logic [15:0]             par_rdata_out,
   output var  logic                    par_rvalid_out,
   // pins
   input  wire logic                    jumper_60hz_in,
   input  wire logic                    ext_present_in,
   // measurements and control period
   input  wire regsel_pkg::ref_val_t    ext_analog_in,
   input  wire regsel_pkg::ref_val_t    voltage_knob_in,
   input  wire logic                    period_tick_in,
   // applied configuration and reference
   output var  regsel_pkg::func_flags_t func_out,
   output var  regsel_pkg::ref_src_t    ref_src_out,
   output var  regsel_pkg::ref_val_t    vref_out,
   output var  logic                    saturated_out,
   output var  regsel_pkg::ref_val_t    volt_setting_out
);
   import regsel_pkg::*;

   logic [15:0] cfg_q;
   logic [15:0] applied_cfg_q;
   ref_val_t    stored_sp_q;
   ref_val_t    ext_limit_q;
   ref_val_t    vout_ref_q;
   ref_val_t    vol_sp_q;
   logic [1:0]  pins_s;
   logic        jumper_s;
   logic        present_s;
   ref_src_t    sel_src;
   ref_val_t    sel_value;
   logic        sel_sat;
   ref_val_t    sel_ceiling;
   logic        wr_cfg;
   logic        wr_stored;
   logic        wr_limit;
   logic        wr_vout;
   logic        wr_vol;
   ref_val_t    wr_clamped;

   // pins come from outside the clock domain
   pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .pin_in   ({ext_present_in, jumper_60hz_in}),
      .sync_out (pins_s)
   );

   assign jumper_s  = pins_s[0];
   assign present_s = pins_s[1];

   // write decode; values above full scale clip rather than wrap
   assign wr_cfg     = par_req_in.wr && (par_req_in.addr == `CFG_WORD_ADDR);
   assign wr_stored  = par_req_in.wr && (par_req_in.addr == `STORED_SP_ADDR);
   assign wr_limit   = par_req_in.wr && (par_req_in.addr == `EXT_LIMIT_ADDR);
   assign wr_vout    = par_req_in.wr && (par_req_in.addr == `VOUT_REF_ADDR);
   assign wr_vol     = par_req_in.wr && (par_req_in.addr == `VOL_SP_ADDR);
   assign wr_clamped = par_req_in.data[15] ? `REF_MAX : par_req_in.data[14:0];

   // configuration word; reserved bits are stored and read back but drive no function
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cfg_q <= `CFG_WORD_RST;
      end else if (wr_cfg) begin
         cfg_q <= par_req_in.data;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         stored_sp_q <= `STORED_SP_RST;
         ext_limit_q <= `EXT_LIMIT_RST;
         vout_ref_q  <= `VOUT_REF_RST;
      end else begin
         if (wr_stored) begin
            stored_sp_q <= wr_clamped;
         end
         if (wr_limit) begin
            ext_limit_q <= wr_clamped;
         end
         if (wr_vout) begin
            vout_ref_q <= wr_clamped;
         end
      end
   end

   // volatile setpoint: reset reload stands in for power loss
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         vol_sp_q <= `STORED_SP_RST;
      end else if (!cfg_q[`B_RAM_CTRL]) begin
         vol_sp_q <= stored_sp_q;
      end else if (wr_vol) begin
         vol_sp_q <= wr_clamped;
      end
   end

   ref_select u_ref_select (
      .ram_ctrl_in    (cfg_q[`B_RAM_CTRL]),
      .ext_en_in      (cfg_q[`B_EXT_IN]),
      .ext_present_in (present_s),
      .ext_analog_in  (ext_analog_in),
      .stored_sp_in   (stored_sp_q),
      .ext_limit_in   (ext_limit_q),
      .vol_sp_in      (vol_sp_q),
      .src_out        (sel_src),
      .value_out      (sel_value),
      .sat_out        (sel_sat),
      .ceiling_out    (sel_ceiling)
   );

   // applied state changes only at a period boundary, never mid-period
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         applied_cfg_q <= `CFG_WORD_RST;
      end else if (period_tick_in) begin
         applied_cfg_q <= cfg_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         func_out <= '0;
      end else if (period_tick_in) begin
         func_out.rms_mode     <= cfg_q[`B_RMS];
         func_out.periodic_var <= cfg_q[`B_PERIODIC];
         func_out.offset_comp  <= cfg_q[`B_OFFSET];
         func_out.avg32        <= cfg_q[`B_AVG32];
         func_out.freq_60hz    <= cfg_q[`B_JUMPER] ? jumper_s : cfg_q[`B_SIXTY_HZ];
         func_out.volt_knob_en <= cfg_q[`B_VOLT_KNOB];
         func_out.stab_knob_en <= cfg_q[`B_STAB_KNOB];
         func_out.freq_knob_en <= cfg_q[`B_FREQ_KNOB];
         func_out.amp_knob_en  <= cfg_q[`B_AMP_KNOB];
         func_out.dac_en       <= cfg_q[`B_DAC];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ref_src_out   <= SRC_STORED;
         vref_out      <= `STORED_SP_RST;
         saturated_out <= 1'b0;
      end else if (period_tick_in) begin
         ref_src_out   <= sel_src;
         vref_out      <= sel_value;
         saturated_out <= sel_sat;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         volt_setting_out <= `VOUT_REF_RST;
      end else if (period_tick_in) begin
         volt_setting_out <= cfg_q[`B_VOLT_KNOB] ? voltage_knob_in : vout_ref_q;
      end
   end

   // read port: one cycle latency, unmapped addresses read zero
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         par_rvalid_out <= 1'b0;
         par_rdata_out  <= 16'h0000;
      end else begin
         par_rvalid_out <= par_req_in.rd;
         if (par_req_in.rd) begin
            case (par_req_in.addr)
               `CFG_WORD_ADDR:   par_rdata_out <= cfg_q;
               `STORED_SP_ADDR:  par_rdata_out <= {1'b0, stored_sp_q};
               `EXT_LIMIT_ADDR:  par_rdata_out <= {1'b0, ext_limit_q};
               `VOUT_REF_ADDR:   par_rdata_out <= {1'b0, vout_ref_q};
               `VOLT_KNOB_ADDR:  par_rdata_out <= {1'b0, voltage_knob_in};
               `ACTIVE_CFG_ADDR: par_rdata_out <= applied_cfg_q;
               `EXT_INPUT_ADDR:  par_rdata_out <= {1'b0, ext_analog_in};
               `SETPOINT_ADDR:   par_rdata_out <= {1'b0, vref_out};
               `VOL_SP_ADDR:     par_rdata_out <= {1'b0, vol_sp_q};
               default:          par_rdata_out <= 16'h0000;
            endcase
         end else begin
            par_rdata_out <= 16'h0000;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_tick_ext_sat;
      period_tick_in && cfg_q[`B_EXT_IN] && cfg_q[`B_RAM_CTRL];
   endsequence

   sequence s_tick_digital;
      period_tick_in && !cfg_q[`B_EXT_IN];
   endsequence

   // host write that lands in the volatile setpoint
   sequence s_vol_write;
      wr_vol && cfg_q[`B_RAM_CTRL];
   endsequence

   AST_CFG_RESET: assert property (
      $rose(rstn_in) |-> (cfg_q == `CFG_WORD_RST) && (vol_sp_q == `STORED_SP_RST))
      else $error("configuration word not at default after reset");

   AST_FLAGS_APPLY: assert property (
      period_tick_in |=> (func_out.rms_mode == $past(cfg_q[`B_RMS]))
                         && (func_out.offset_comp == $past(cfg_q[`B_OFFSET])))
      else $error("rms or offset flag not taken at tick");

   AST_PERIODIC: assert property (
      period_tick_in |=> func_out.periodic_var == $past(cfg_q[`B_PERIODIC]))
      else $error("periodic variation flag wrong");

   AST_AVG32: assert property (
      period_tick_in |=> func_out.avg32 == $past(cfg_q[`B_AVG32]))
      else $error("32 sample flag wrong");

   AST_FREQ_JUMPER: assert property (
      period_tick_in && cfg_q[`B_JUMPER] |=> func_out.freq_60hz == $past(jumper_s))
      else $error("frequency not from jumper");

   AST_FREQ_BIT: assert property (
      period_tick_in && !cfg_q[`B_JUMPER] |=> func_out.freq_60hz == $past(cfg_q[`B_SIXTY_HZ]))
      else $error("frequency not from bit 14");

   AST_EXT_PLAIN: assert property (
      period_tick_in && cfg_q[`B_EXT_IN] && !cfg_q[`B_RAM_CTRL]
      |=> (ref_src_out == SRC_ANALOG) && (vref_out == $past(ext_analog_in)) && !saturated_out)
      else $error("analog input not followed unsaturated");

   AST_SAT_LOST: assert property (
      s_tick_ext_sat and !present_s |=> saturated_out && (vref_out == $past(sel_ceiling)))
      else $error("lost input did not go to ceiling");

   AST_SAT_LIMIT: assert property (
      s_tick_ext_sat |=> vref_out <= $past(sel_ceiling))
      else $error("saturated reference above ceiling");

   AST_STORED: assert property (
      s_tick_digital and !cfg_q[`B_RAM_CTRL] |=> vref_out == $past(stored_sp_q))
      else $error("stored setpoint not used");

   AST_VOLATILE: assert property (
      s_tick_digital and cfg_q[`B_RAM_CTRL] |=> vref_out == $past(vol_sp_q))
      else $error("volatile setpoint not used");

   AST_VOL_TRACK: assert property (
      !cfg_q[`B_RAM_CTRL] ##1 !cfg_q[`B_RAM_CTRL] |-> vol_sp_q == $past(stored_sp_q))
      else $error("volatile setpoint not aligned to stored");

   AST_HOLD: assert property (
      !period_tick_in |=> $stable(vref_out) && $stable(ref_src_out))
      else $error("reference changed between periods");

   AST_KNOB: assert property (
      period_tick_in && !cfg_q[`B_VOLT_KNOB] |=> volt_setting_out == $past(vout_ref_q))
      else $error("stored reference not replacing knob");

   AST_KNOB_ON: assert property (
      period_tick_in && cfg_q[`B_VOLT_KNOB] |=> volt_setting_out == $past(voltage_knob_in))
      else $error("knob position not used while enabled");

   AST_CFG_WRITE: assert property (
      wr_cfg |=> cfg_q == $past(par_req_in.data))
      else $error("configuration word write not stored");

   AST_KNOB_FLAGS: assert property (
      period_tick_in |=> (func_out.volt_knob_en == $past(cfg_q[`B_VOLT_KNOB]))
                         && (func_out.stab_knob_en == $past(cfg_q[`B_STAB_KNOB]))
                         && (func_out.freq_knob_en == $past(cfg_q[`B_FREQ_KNOB]))
                         && (func_out.amp_knob_en == $past(cfg_q[`B_AMP_KNOB]))
                         && (func_out.dac_en == $past(cfg_q[`B_DAC])))
      else $error("knob or converter enable not taken at tick");

   AST_EXT_IGNORED: assert property (
      s_tick_digital |=> (ref_src_out == SRC_STORED) || (ref_src_out == SRC_VOLATILE))
      else $error("analog input used while disabled");

   AST_SAT_SRC: assert property (
      s_tick_ext_sat |=> ref_src_out == SRC_ANALOG_SAT)
      else $error("bit 7 with analog input did not select saturation");

   AST_SAT_FOLLOW: assert property (
      s_tick_ext_sat and (present_s && (ext_analog_in < sel_ceiling))
      |=> !saturated_out && (vref_out == $past(ext_analog_in)))
      else $error("analog input below ceiling not followed");

   AST_VOL_WRITE: assert property (
      s_vol_write |=> vol_sp_q == $past(wr_clamped))
      else $error("volatile setpoint write lost");

   AST_VOL_CLAMP: assert property (
      s_vol_write and par_req_in.data[15] |=> vol_sp_q == `REF_MAX)
      else $error("volatile setpoint above full scale not clipped");

   AST_VOL_READ: assert property (
      par_req_in.rd && (par_req_in.addr == `VOL_SP_ADDR)
      |=> par_rvalid_out && (par_rdata_out == {1'b0, $past(vol_sp_q)}))
      else $error("volatile setpoint read back wrong");

   AST_VOL_HOLD: assert property (
      cfg_q[`B_RAM_CTRL] && !wr_vol |=> $stable(vol_sp_q))
      else $error("volatile setpoint changed without a write");

   AST_APPLIED: assert property (
      period_tick_in |=> applied_cfg_q == $past(cfg_q))
      else $error("active configuration not captured at tick");

endmodule // regulator_config_setpoint_select

`default_nettype wire

//--- hw/regsel_cfg.svh
`ifndef REGSEL_CFG_SVH
`define REGSEL_CFG_SVH

// parameter and location addresses on the serial parameter port
`define CFG_WORD_ADDR   6'h0a
`define STORED_SP_ADDR  6'h0f
`define EXT_LIMIT_ADDR  6'h10
`define VOUT_REF_ADDR   6'h13
`define VOLT_KNOB_ADDR  6'h20
`define ACTIVE_CFG_ADDR 6'h27
`define EXT_INPUT_ADDR  6'h29
`define SETPOINT_ADDR   6'h2a
`define VOL_SP_ADDR     6'h31

// configuration word bit positions
`define B_RMS        0
`define B_PERIODIC   1
`define B_OFFSET     2
`define B_AVG32      3
`define B_JUMPER     4
`define B_RAM_CTRL   7
`define B_VOLT_KNOB  8
`define B_STAB_KNOB  9
`define B_FREQ_KNOB  10
`define B_AMP_KNOB   11
`define B_EXT_IN     12
`define B_DAC        13
`define B_SIXTY_HZ   14

// reset values and full scale
`define CFG_WORD_RST  16'h1f1d
`define STORED_SP_RST 15'h4000
`define EXT_LIMIT_RST 15'h1200
`define VOUT_REF_RST  15'h0000
`define REF_MAX       15'h7fff

`endif

//--- hw/regsel_pkg.sv
package regsel_pkg;

   typedef logic [14:0] ref_val_t;

   typedef enum logic [1:0] {
      SRC_ANALOG,
      SRC_ANALOG_SAT,
      SRC_STORED,
      SRC_VOLATILE
   } ref_src_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  addr;
      logic [15:0] data;
   } par_req_t;

   typedef struct packed {
      logic rms_mode;
      logic periodic_var;
      logic offset_comp;
      logic avg32;
      logic freq_60hz;
      logic volt_knob_en;
      logic stab_knob_en;
      logic freq_knob_en;
      logic amp_knob_en;
      logic dac_en;
   } func_flags_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter int unsigned WIDTH = 2
)(
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   // raw pins and synchronised levels
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         // one process per bit owns its own flops, not a slice of a shared port
         always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= pin_in[i];
               sync_q <= meta_q;
            end
         end
         assign sync_out[i] = sync_q;
      end
   endgenerate

endmodule // pin_sync

`default_nettype wire

//--- hw/ref_select.sv
`include "regsel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ref_select (
   // selection controls
   input  wire logic                 ram_ctrl_in,
   input  wire logic                 ext_en_in,
   input  wire logic                 ext_present_in,
   // candidate values
   input  wire regsel_pkg::ref_val_t ext_analog_in,
   input  wire regsel_pkg::ref_val_t stored_sp_in,
   input  wire regsel_pkg::ref_val_t ext_limit_in,
   input  wire regsel_pkg::ref_val_t vol_sp_in,
   // result
   output var  regsel_pkg::ref_src_t src_out,
   output var  regsel_pkg::ref_val_t value_out,
   output var  logic                 sat_out,
   output var  regsel_pkg::ref_val_t ceiling_out
);
   import regsel_pkg::*;

   logic [15:0] sum;

   // ceiling is stored setpoint plus the allowed excursion, clipped to full scale
   always_comb begin
      sum = {1'b0, stored_sp_in} + {1'b0, ext_limit_in};
      ceiling_out = sum[15] ? `REF_MAX : sum[14:0];
   end

   always_comb begin
      src_out   = SRC_STORED;
      value_out = stored_sp_in;
      sat_out   = 1'b0;
      if (ext_en_in && ram_ctrl_in) begin
         src_out = SRC_ANALOG_SAT;
         // a lost input must not read as zero volts, so it pins to the ceiling
         if (!ext_present_in || (ext_analog_in >= ceiling_out)) begin
            value_out = ceiling_out;
            sat_out   = 1'b1;
         end else begin
            value_out = ext_analog_in;
         end
      end else if (ext_en_in) begin
         src_out   = SRC_ANALOG;
         value_out = ext_analog_in;
      end else if (ram_ctrl_in) begin
         src_out   = SRC_VOLATILE;
         value_out = vol_sp_in;
      end
   end

endmodule // ref_select

`default_nettype wire

//--- verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_model (
   // clock
   input  wire logic                 clk_in,
   // parameter port
   output var  regsel_pkg::par_req_t par_req_out,
   input  wire logic [15:0]          par_rdata_in,
   input  wire logic                 par_rvalid_in
);
   import regsel_pkg::*;

   initial par_req_out = '{1'b0, 1'b0, 6'h15, 16'ha5a5};

   // idle lines after a write show the inverse of the last value; after a read the data goes back to its earlier value
   task automatic put(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = (a == 6'h0a) ? (d & 16'h7f9f) : d;
      @(negedge clk_in);
      if (a >= 6'h0a) par_req_out = '{1'b1, 1'b0, a, v};
      @(negedge clk_in);
      par_req_out = '{1'b0, 1'b0, ~a, ~v};
   endtask

   task automatic get(input logic [5:0] a, output logic [15:0] d, output logic vld);
      @(negedge clk_in);
      par_req_out = '{1'b0, 1'b1, a, ~par_req_out.data};
      @(negedge clk_in);
      d = par_rdata_in;
      vld = par_rvalid_in;
      par_req_out = '{1'b0, 1'b0, ~a, ~par_req_out.data};
   endtask
endmodule // host_model

`default_nettype wire

//--- verif/tb.sv
`include "regsel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module tb;
   import regsel_pkg::*;

   logic        clk_in, rstn_in, jumper_60hz_in, ext_present_in, period_tick_in, sat;
   par_req_t    par_req;
   logic [15:0] par_rdata;
   logic        par_rvalid;
   ref_val_t    ext_analog_in, voltage_knob_in, vref, vset;
   func_flags_t func;
   ref_src_t    src;
   int          err_total, compares, seed, m_sp, m_lim, m_vout, m_vol;
   logic [15:0] m_cfg, c;
   logic [42:0] held;

   regulator_config_setpoint_select u_dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .par_req_in(par_req),
      .par_rdata_out(par_rdata), .par_rvalid_out(par_rvalid),
      .jumper_60hz_in(jumper_60hz_in), .ext_present_in(ext_present_in),
      .ext_analog_in(ext_analog_in), .voltage_knob_in(voltage_knob_in),
      .period_tick_in(period_tick_in), .func_out(func), .ref_src_out(src),
      .vref_out(vref), .saturated_out(sat), .volt_setting_out(vset));

   host_model u_host (
      .clk_in(clk_in), .par_req_out(par_req),
      .par_rdata_in(par_rdata), .par_rvalid_in(par_rvalid));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   task automatic tally_and_finish();
      if (err_total == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: read got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_outs(input logic [42:0] got, input logic [42:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: outputs got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [42:0] expect_outs();
      func_flags_t f;
      ref_src_t    s;
      int          v, ceil;
      logic        st;
      f = '{m_cfg[0], m_cfg[1], m_cfg[2], m_cfg[3], m_cfg[4] ? jumper_60hz_in : m_cfg[14],
            m_cfg[8], m_cfg[9], m_cfg[10], m_cfg[11], m_cfg[13]};
      ceil = (m_sp + m_lim > 32767) ? 32767 : m_sp + m_lim;
      st = 1'b0;
      if (m_cfg[12] && m_cfg[7]) begin
         s = SRC_ANALOG_SAT;
         st = !ext_present_in || (ext_analog_in >= ceil);
         v = st ? ceil : ext_analog_in;
      end else if (m_cfg[12]) begin
         s = SRC_ANALOG;
         v = ext_analog_in;
      end else if (m_cfg[7]) begin
         s = SRC_VOLATILE;
         v = m_vol;
      end else begin
         s = SRC_STORED;
         v = m_sp;
      end
      return {f, s, v[14:0], st, m_cfg[8] ? voltage_knob_in : m_vout[14:0]};
   endfunction

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [14:0] dc;
      dc = d[15] ? 15'h7fff : d[14:0];
      u_host.put(a, d);
      case (a)
         `CFG_WORD_ADDR:  m_cfg = d & 16'h7f9f;
         `STORED_SP_ADDR: m_sp = dc;
         `EXT_LIMIT_ADDR: m_lim = dc;
         `VOUT_REF_ADDR:  m_vout = dc;
         `VOL_SP_ADDR:    if (m_cfg[7]) m_vol = dc;
         default: ;
      endcase
      if (!m_cfg[7]) m_vol = m_sp;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      u_host.get(a, d, v);
      chk_word({v, d}, {1'b1, exp});
   endtask

   task automatic tick_chk();
      @(negedge clk_in);
      period_tick_in = 1'b1;
      @(negedge clk_in);
      period_tick_in = 1'b0;
      chk_outs({func, src, vref, sat, vset}, expect_outs());
   endtask

   // short reset stands in for a power cycle of the volatile setpoint
   task automatic do_reset(input int n);
      logic [5:0]  adr [6] = '{6'h0a, 6'h0f, 6'h10, 6'h13, 6'h31, 6'h3f};
      logic [15:0] val [6] = '{16'h1f1d, 16'h4000, 16'h1200, 16'h0, 16'h4000, 16'h0};
      @(negedge clk_in);
      rstn_in = 1'b0;
      repeat (n) @(negedge clk_in);
      rstn_in = 1'b1;
      m_cfg = 16'h1f1d;
      m_sp = 32'h4000;
      m_lim = 32'h1200;
      m_vout = 0;
      m_vol = 32'h4000;
      chk_outs({func, src, vref, sat, vset}, {10'h0, SRC_STORED, 15'h4000, 1'b0, 15'h0});
      for (int i = 0; i < 6; i++) rd_chk(adr[i], val[i]);
   endtask

   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      tally_and_finish();
   end

   initial begin
      seed = 32'h6c2a;
      err_total = 0;
      compares = 0;
      rstn_in = 1'b0;
      jumper_60hz_in = 1'b0;
      ext_present_in = 1'b1;
      ext_analog_in = 15'h0;
      voltage_knob_in = 15'h0;
      period_tick_in = 1'b0;
      repeat (10) @(negedge clk_in);
      do_reset(1);
      for (int i = 0; i < 24; i++) begin
         @(negedge clk_in);
         jumper_60hz_in = 1'($random(seed));
         ext_present_in = ($random(seed) & 3) != 0;
         ext_analog_in = 15'($random(seed));
         voltage_knob_in = 15'($random(seed));
         c = 16'($random(seed)) & 16'h6f1f;
         c[7] = i[0];
         c[12] = i[1];
         wr(`STORED_SP_ADDR, {1'b0, 15'($random(seed))});
         wr(`EXT_LIMIT_ADDR, 16'($random(seed) & 16'h1fff));
         wr(`VOUT_REF_ADDR, 16'($random(seed)));
         wr(`CFG_WORD_ADDR, c);
         wr(`VOL_SP_ADDR, (i % 8 == 3) ? 16'hc000 : {1'b0, 15'($random(seed))});
         rd_chk(`CFG_WORD_ADDR, m_cfg);
         rd_chk(`VOL_SP_ADDR, m_vol[15:0]);
         tick_chk();
         held = expect_outs();
         rd_chk(`SETPOINT_ADDR, {1'b0, held[30:16]});
         rd_chk(`EXT_INPUT_ADDR, {1'b0, ext_analog_in});
         rd_chk(`VOLT_KNOB_ADDR, {1'b0, voltage_knob_in});
         // config changes between ticks must not reach the outputs
         c = m_cfg;
         wr(`CFG_WORD_ADDR, m_cfg ^ 16'h1080);
         chk_outs({func, src, vref, sat, vset}, held);
         rd_chk(`ACTIVE_CFG_ADDR, c);
      end
      wr(`CFG_WORD_ADDR, 16'h0080);
      wr(`VOL_SP_ADDR, 16'h1234);
      rd_chk(`VOL_SP_ADDR, 16'h1234);
      do_reset(2);
      tally_and_finish();
   end
endmodule // tb

`default_nettype wire
